// *** test/ctg_host_model.sv ***
// host model driving the internal register bus
`timescale 1ns/10ps
module ctg_host_model (
  // clock
  input wire logic clk,
  // register bus
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic rd_hit
);
  initial begin
    addr = 8'hFF;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk) #1;
    wr_en = 1'b0;
    wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk) #1;
    addr = a;
    rd_en = 1'b1;
    @(posedge clk) #1;
    rd_en = 1'b0;
    addr = ~a;
    h = rd_hit;
    d = rdata;
  endtask : rd
endmodule : ctg_host_model

// *** test/ctg_regs_checker.sv ***
// port assertions for the colour tile gain register bank
`timescale 1ns/10ps
module ctg_regs_checker (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // register bus
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] RDATA,
  input wire logic RD_HIT,
  // pixel path
  input wire logic FRAME_START,
  input wire logic PIX_VALID,
  input wire logic [1:0] PIX_ROW,
  input wire logic [1:0] PIX_COL,
  input wire logic PIX_GAIN_VALID,
  input wire logic [1:0] PIX_COLOUR_SEL,
  input wire logic [5:0] PIX_GAIN_CODE,
  // analog controls
  input wire logic [7:0] LOWER_REF_CODE,
  input wire logic [7:0] UPPER_REF_CODE,
  input wire logic BIAS_PIN_SEL,
  input wire logic SOFT_STANDBY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // write data of the previous edge
  logic [7:0] wdata_ff;
  always_ff @(posedge CLOCK) begin
    wdata_ff <= WDATA;
  end
  // ==========================================================
  // register bus
  a_read_hit_pulse: assert property (RD_EN && ADDR < 8'h10 |=> RD_HIT)
    else $error("in-block read gave no hit");
  a_miss_no_hit: assert property (!(RD_EN && ADDR < 8'h10) |=> !RD_HIT)
    else $error("hit without in-block read");
  a_miss_keeps_data: assert property (!(RD_EN && ADDR < 8'h10) |=> $stable(RDATA))
    else $error("read data moved without in-block read");
  a_gain_high_zero: assert property (RD_EN && ADDR < 8'h04 |=> RDATA[7:6] == 2'b00)
    else $error("gain unused bits not zero");
  a_tile_high_zero: assert property (RD_EN && ADDR == 8'h05 |=> RDATA[7:4] == 4'h0)
    else $error("tile shape unused bits not zero");
  a_power_unused_zero: assert property (RD_EN && ADDR == 8'h0C |=> (RDATA & 8'hF6) == 8'h00)
    else $error("power unused bits not zero");
  // ==========================================================
  // analog controls
  a_lower_ref_write: assert property (WR_EN && ADDR == 8'h0A |=> LOWER_REF_CODE == wdata_ff)
    else $error("lower reference not written");
  a_upper_ref_write: assert property (WR_EN && ADDR == 8'h0B |=> UPPER_REF_CODE == wdata_ff)
    else $error("upper reference not written");
  a_power_bits_write: assert property (WR_EN && ADDR == 8'h0C |=>
    BIAS_PIN_SEL == wdata_ff[3] && SOFT_STANDBY == wdata_ff[0])
    else $error("power bits not written");
  // ==========================================================
  // pixel path
  a_pix_latency: assert property (PIX_VALID |=> PIX_GAIN_VALID)
    else $error("pixel lookup late");
  a_pix_idle_hold: assert property (!PIX_VALID |=> !PIX_GAIN_VALID &&
    $stable(PIX_COLOUR_SEL) && $stable(PIX_GAIN_CODE))
    else $error("pixel outputs moved without pixel");
endmodule : ctg_regs_checker

bind ctg_regs ctg_regs_checker chk (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .RD_HIT(RD_HIT),
  .FRAME_START(FRAME_START), .PIX_VALID(PIX_VALID), .PIX_ROW(PIX_ROW), .PIX_COL(PIX_COL),
  .PIX_GAIN_VALID(PIX_GAIN_VALID), .PIX_COLOUR_SEL(PIX_COLOUR_SEL),
  .PIX_GAIN_CODE(PIX_GAIN_CODE), .LOWER_REF_CODE(LOWER_REF_CODE),
  .UPPER_REF_CODE(UPPER_REF_CODE), .BIAS_PIN_SEL(BIAS_PIN_SEL), .SOFT_STANDBY(SOFT_STANDBY));

// *** test/test_ctg_regs.sv ***
// self-checking bench for the colour tile gain register bank
`timescale 1ns/10ps
`include "ctg_consts.svh"
module test_ctg_regs;
  import ctg_pkg::*;
  logic clock, rst_n, wr_en, rd_en, rd_hit, frame_start, pix_valid, gvalid, bias, stby;
  logic [7:0] addr, wdata, rdata, lref, uref, last, wa, wd;
  logic [1:0] prow, pcol, psel;
  logic [5:0] pcode;
  ctg_byte_t mem [16];
  integer seed = 36880;
  integer errors = 0;
  integer num_checks = 0;
  integer i;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ctg_host_model host (.clk(clock), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .rd_hit(rd_hit));
  ctg_regs dut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en),
    .RD_EN(rd_en), .RDATA(rdata), .RD_HIT(rd_hit), .FRAME_START(frame_start),
    .PIX_VALID(pix_valid), .PIX_ROW(prow), .PIX_COL(pcol), .PIX_GAIN_VALID(gvalid),
    .PIX_COLOUR_SEL(psel), .PIX_GAIN_CODE(pcode), .LOWER_REF_CODE(lref),
    .UPPER_REF_CODE(uref), .BIAS_PIN_SEL(bias), .SOFT_STANDBY(stby));
  // ==========================================================
  // checking and expectation helpers
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h00, 8'h01, 8'h02, 8'h03: return 8'h3F;
      8'h05: return 8'h0F;
      8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B: return 8'hFF;
      8'h0C: return 8'h09;
      default: return 8'h00;
    endcase
  endfunction : msk
  function automatic logic [1:0] tix(input logic [1:0] f, input logic [1:0] n);
    return (f == 2'b00) ? 2'b00 : (f == 2'b01) ? {1'b0, n[0]} : n;
  endfunction : tix
  ctg_gain_t act [4];
  // ==========================================================
  // bus and pixel tasks
  task automatic outs;
    check("lower_ref", lref, mem[10]);
    check("upper_ref", uref, mem[11]);
    check("power", {4'h0, bias, 2'b00, stby}, mem[12]);
  endtask : outs
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (msk(a) != 8'h00) mem[a[3:0]] = d & msk(a);
    outs();
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    logic [7:0] v;
    logic h;
    host.rd(a, v, h);
    if (a < 8'h10) last = (a == 8'h0F) ? `CTG_IDENT_VALUE : mem[a[3:0]];
    check("rd_hit", {7'h00, h}, {7'h00, a < 8'h10});
    check("rdata", v, last);
  endtask : rreg
  task automatic pix(input logic [1:0] r, input logic [1:0] c);
    logic [7:0] s;
    s = mem[6 + tix(mem[5][1:0], r)] >> (2 * tix(mem[5][3:2], c));
    @(posedge clock) #1;
    pix_valid = 1'b1;
    prow = r;
    pcol = c;
    @(posedge clock) #1;
    pix_valid = 1'b0;
    check("pix_valid", {7'h00, gvalid}, 8'h01);
    check("pix_sel", {6'h00, psel}, {6'h00, s[1:0]});
    check("pix_code", {2'b00, pcode}, {2'b00, act[s[1:0]]});
  endtask : pix
  task automatic frame;
    @(posedge clock) #1;
    frame_start = 1'b1;
    @(posedge clock) #1;
    frame_start = 1'b0;
    for (int k = 0; k < 4; k++) act[k] = mem[k][5:0];
  endtask : frame
  task automatic test_done;
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    frame_start = 1'b0;
    pix_valid = 1'b0;
    prow = 2'b00;
    pcol = 2'b00;
    last = 8'h00;
    for (i = 0; i < 16; i++) mem[i] = (i < 4) ? 8'h02 : 8'h00;
    for (i = 0; i < 4; i++) act[i] = 6'h02;
    mem[5] = 8'h05;
    mem[6] = 8'h44;
    mem[7] = 8'hEE;
    mem[10] = 8'h76;
    mem[11] = 8'h80;
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    outs();
    for (i = 0; i < 17; i++) rreg(i[7:0]);
    for (i = 0; i < 16; i++) pix(i[3:2], i[1:0]);
    for (i = 0; i < 80; i++) begin
      wa = 8'($random(seed) & 15);
      wd = 8'($random(seed));
      if (wa == 8'h0A || wa == 8'h0B) begin
        wreg(8'h0A, wd);
        wreg(8'h0B, wd);
      end else begin
        wreg(wa, wd);
      end
      rreg(8'($random(seed) & 15));
    end
    rreg(8'($random(seed)) | 8'h10);
    frame();
    for (i = 0; i < 30; i++) pix(2'($random(seed)), 2'($random(seed)));
    for (i = 0; i < 4; i++) wreg(i[7:0], 8'($random(seed)));
    for (i = 0; i < 8; i++) pix(2'($random(seed)), 2'($random(seed)));
    frame();
    for (i = 0; i < 16; i++) pix(i[3:2], i[1:0]);
    test_done();
  end
  initial begin
    #2000000;
    errors++;
    test_done();
  end
endmodule : test_ctg_regs

// *** verilog/ctg_consts.svh ***
// register offsets, field positions, reset values for the colour tile gain bank
`ifndef CTG_CONSTS_SVH
`define CTG_CONSTS_SVH

// ==========================================================
// block address window
`define CTG_BLOCK_BASE 8'h00
`define CTG_BLOCK_LAST 8'h0F

// ==========================================================
// register offsets
`define CTG_OFS_RED_GAIN 8'h00
`define CTG_OFS_GREEN_RED_GAIN 8'h01
`define CTG_OFS_GREEN_BLUE_GAIN 8'h02
`define CTG_OFS_BLUE_GAIN 8'h03
`define CTG_OFS_TILE_SHAPE 8'h05
`define CTG_OFS_ROW_ONE 8'h06
`define CTG_OFS_ROW_TWO 8'h07
`define CTG_OFS_ROW_THREE 8'h08
`define CTG_OFS_ROW_FOUR 8'h09
`define CTG_OFS_LOWER_REF 8'h0A
`define CTG_OFS_UPPER_REF 8'h0B
`define CTG_OFS_POWER 8'h0C
`define CTG_OFS_IDENT 8'h0F

// ==========================================================
// field positions
`define CTG_GAIN_MSB 5
`define CTG_TILE_COL_MSB 3
`define CTG_TILE_COL_LSB 2
`define CTG_TILE_ROW_MSB 1
`define CTG_TILE_ROW_LSB 0
`define CTG_PWR_BIAS_BIT 3
`define CTG_PWR_STANDBY_BIT 0

// ==========================================================
// write masks, unused bits read as zero
`define CTG_MASK_GAIN 8'h3F
`define CTG_MASK_TILE_SHAPE 8'h0F
`define CTG_MASK_POWER 8'h09

// ==========================================================
// reset values
`define CTG_RST_GAIN 6'h02
`define CTG_RST_TILE_SHAPE 8'h05
`define CTG_RST_ROW_ONE 8'h44
`define CTG_RST_ROW_TWO 8'hEE
`define CTG_RST_ROW_THREE 8'h00
`define CTG_RST_ROW_FOUR 8'h00
`define CTG_RST_LOWER_REF 8'h76
`define CTG_RST_UPPER_REF 8'h80
`define CTG_RST_POWER 8'h00
`define CTG_RST_BIAS_SEL 1'h0
`define CTG_RST_STANDBY 1'h0

// arbitrary identification value
`define CTG_IDENT_VALUE 8'h5A

`endif

// *** verilog/ctg_gain_bank.sv ***
// four colour gain codes with frame-boundary shadow copies
`timescale 1ns/10ps
`include "ctg_consts.svh"
module ctg_gain_bank
  import ctg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register side
  ctg_gain_if.bank gif
);

  ctg_gain_t live_ff [4];
  ctg_gain_t active_ff [4];

  // ==========================================================
  // per colour storage
  for (genvar i = 0; i < 4; i++) begin : g_col
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        live_ff[i] <= `CTG_RST_GAIN;
      end else if (gif.wr_en && gif.wr_idx == ctg_sel_t'(i)) begin
        live_ff[i] <= gif.wr_data;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        active_ff[i] <= `CTG_RST_GAIN;
      end else if (gif.frame_sync) begin
        active_ff[i] <= live_ff[i];
      end
    end

    assign gif.live[i] = live_ff[i];
    assign gif.active[i] = active_ff[i];
  end

endmodule : ctg_gain_bank

// *** verilog/ctg_gain_if.sv ***
// carrier between register decode and the shadowed gain bank
`timescale 1ns/10ps
interface ctg_gain_if;
  import ctg_pkg::*;
  logic wr_en;
  ctg_sel_t wr_idx;
  ctg_gain_t wr_data;
  logic frame_sync;
  ctg_gain_arr_t live;
  ctg_gain_arr_t active;
  modport bank (
    input wr_en,
    input wr_idx,
    input wr_data,
    input frame_sync,
    output live,
    output active
  );
  modport ctrl (
    output wr_en,
    output wr_idx,
    output wr_data,
    output frame_sync,
    input live,
    input active
  );
endinterface : ctg_gain_if

// *** verilog/ctg_pkg.sv ***
// types shared by the colour tile gain bank
package ctg_pkg;
  typedef logic [5:0] ctg_gain_t;
  typedef logic [7:0] ctg_byte_t;
  typedef logic [1:0] ctg_sel_t;
  typedef ctg_gain_t ctg_gain_arr_t [4];
  typedef enum logic [1:0] {
    CTG_TILE_ONE = 2'b00,
    CTG_TILE_TWO = 2'b01,
    CTG_TILE_FOUR = 2'b10
  } ctg_tile_n_t;
endpackage : ctg_pkg

// *** verilog/ctg_regs.sv ***
// analog configuration register bank: colour gains, tile map, references, power
`timescale 1ns/10ps
`include "ctg_consts.svh"
module ctg_regs
  import ctg_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // internal control bus
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RDATA,
  output logic RD_HIT,
  // sensor timing
  input wire logic FRAME_START,
  input wire logic PIX_VALID,
  input wire logic [1:0] PIX_ROW,
  input wire logic [1:0] PIX_COL,
  // pixel gain path
  output logic PIX_GAIN_VALID,
  output logic [1:0] PIX_COLOUR_SEL,
  output logic [5:0] PIX_GAIN_CODE,
  // analog controls
  output logic [7:0] LOWER_REF_CODE,
  output logic [7:0] UPPER_REF_CODE,
  output logic BIAS_PIN_SEL,
  output logic SOFT_STANDBY
);

  ctg_gain_if gif ();

  logic in_block;
  logic wr_hit;
  logic rd_take;
  logic wr_gain;
  logic wr_tile_shape;
  logic wr_row_one;
  logic wr_row_two;
  logic wr_row_three;
  logic wr_row_four;
  logic wr_lower_ref;
  logic wr_upper_ref;
  logic wr_power;
  logic bias_sel_ff;
  logic standby_ff;
  ctg_byte_t tile_shape_ff;
  ctg_byte_t row_def_ff [4];
  ctg_byte_t lower_ref_ff;
  ctg_byte_t upper_ref_ff;
  ctg_byte_t rdata_ff;
  ctg_byte_t nxt_rdata;
  logic rd_hit_ff;
  logic pix_valid_ff;
  ctg_sel_t colour_sel_ff;
  ctg_gain_t gain_code_ff;
  ctg_sel_t tile_row;
  ctg_sel_t tile_col;
  ctg_sel_t nxt_colour_sel;
  ctg_byte_t sel_row_def;

  // ==========================================================
  // address decode
  assign in_block = (ADDR <= `CTG_BLOCK_LAST);
  assign wr_hit = WR_EN && in_block;
  assign rd_take = RD_EN && in_block;

  // ==========================================================
  // per register write strobes
  assign wr_gain = wr_hit && (ADDR <= `CTG_OFS_BLUE_GAIN);
  assign wr_tile_shape = wr_hit && (ADDR == `CTG_OFS_TILE_SHAPE);
  assign wr_row_one = wr_hit && (ADDR == `CTG_OFS_ROW_ONE);
  assign wr_row_two = wr_hit && (ADDR == `CTG_OFS_ROW_TWO);
  assign wr_row_three = wr_hit && (ADDR == `CTG_OFS_ROW_THREE);
  assign wr_row_four = wr_hit && (ADDR == `CTG_OFS_ROW_FOUR);
  assign wr_lower_ref = wr_hit && (ADDR == `CTG_OFS_LOWER_REF);
  assign wr_upper_ref = wr_hit && (ADDR == `CTG_OFS_UPPER_REF);
  assign wr_power = wr_hit && (ADDR == `CTG_OFS_POWER);

  // ==========================================================
  // gain bank
  assign gif.wr_en = wr_gain;
  assign gif.wr_idx = ADDR[1:0];
  assign gif.wr_data = ctg_gain_t'(WDATA & `CTG_MASK_GAIN);
  assign gif.frame_sync = FRAME_START;

  ctg_gain_bank u_gain_bank (
    .clk (CLOCK),
    .rst_n (RST_N),
    .gif (gif.bank)
  );

  // ==========================================================
  // tile shape
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tile_shape_ff <= `CTG_RST_TILE_SHAPE;
    end else if (wr_tile_shape) begin
      tile_shape_ff <= WDATA & `CTG_MASK_TILE_SHAPE;
    end
  end

  // ==========================================================
  // row definitions
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      row_def_ff[0] <= `CTG_RST_ROW_ONE;
    end else if (wr_row_one) begin
      row_def_ff[0] <= WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      row_def_ff[1] <= `CTG_RST_ROW_TWO;
    end else if (wr_row_two) begin
      row_def_ff[1] <= WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      row_def_ff[2] <= `CTG_RST_ROW_THREE;
    end else if (wr_row_three) begin
      row_def_ff[2] <= WDATA;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      row_def_ff[3] <= `CTG_RST_ROW_FOUR;
    end else if (wr_row_four) begin
      row_def_ff[3] <= WDATA;
    end
  end

  // ==========================================================
  // lower reference code
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      lower_ref_ff <= `CTG_RST_LOWER_REF;
    end else if (wr_lower_ref) begin
      lower_ref_ff <= WDATA;
    end
  end

  // ==========================================================
  // upper reference code
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      upper_ref_ff <= `CTG_RST_UPPER_REF;
    end else if (wr_upper_ref) begin
      upper_ref_ff <= WDATA;
    end
  end

  // ==========================================================
  // bias source select
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      bias_sel_ff <= `CTG_RST_BIAS_SEL;
    end else if (wr_power) begin
      bias_sel_ff <= WDATA[`CTG_PWR_BIAS_BIT];
    end
  end

  // ==========================================================
  // soft standby
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      standby_ff <= `CTG_RST_STANDBY;
    end else if (wr_power) begin
      standby_ff <= WDATA[`CTG_PWR_STANDBY_BIT];
    end
  end

  // ==========================================================
  // read back
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (ADDR)
      `CTG_OFS_RED_GAIN,
      `CTG_OFS_GREEN_RED_GAIN,
      `CTG_OFS_GREEN_BLUE_GAIN,
      `CTG_OFS_BLUE_GAIN: nxt_rdata = {2'b00, gif.live[ADDR[1:0]]};
      `CTG_OFS_TILE_SHAPE: nxt_rdata = tile_shape_ff;
      `CTG_OFS_ROW_ONE: nxt_rdata = row_def_ff[0];
      `CTG_OFS_ROW_TWO: nxt_rdata = row_def_ff[1];
      `CTG_OFS_ROW_THREE: nxt_rdata = row_def_ff[2];
      `CTG_OFS_ROW_FOUR: nxt_rdata = row_def_ff[3];
      `CTG_OFS_LOWER_REF: nxt_rdata = lower_ref_ff;
      `CTG_OFS_UPPER_REF: nxt_rdata = upper_ref_ff;
      `CTG_OFS_POWER: nxt_rdata = {4'h0, bias_sel_ff, 2'h0, standby_ff};
      `CTG_OFS_IDENT: nxt_rdata = `CTG_IDENT_VALUE;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // read hit
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_hit_ff <= 1'b0;
    end else begin
      rd_hit_ff <= rd_take;
    end
  end

  // ==========================================================
  // read data register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_ff <= 8'h00;
    end else if (rd_take) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // tile position
  always_comb begin
    tile_row = 2'b00;
    if (tile_shape_ff[`CTG_TILE_ROW_MSB]) begin
      tile_row = PIX_ROW;
    end else if (tile_shape_ff[`CTG_TILE_ROW_LSB]) begin
      tile_row = {1'b0, PIX_ROW[0]};
    end
  end

  always_comb begin
    tile_col = 2'b00;
    if (tile_shape_ff[`CTG_TILE_COL_MSB]) begin
      tile_col = PIX_COL;
    end else if (tile_shape_ff[`CTG_TILE_COL_LSB]) begin
      tile_col = {1'b0, PIX_COL[0]};
    end
  end

  // ==========================================================
  // selector lookup
  assign sel_row_def = row_def_ff[tile_row];
  assign nxt_colour_sel = sel_row_def[{tile_col, 1'b0} +: 2];

  // ==========================================================
  // pixel valid
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pix_valid_ff <= 1'b0;
    end else begin
      pix_valid_ff <= PIX_VALID;
    end
  end

  // ==========================================================
  // colour selector
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      colour_sel_ff <= 2'b00;
    end else if (PIX_VALID) begin
      colour_sel_ff <= nxt_colour_sel;
    end
  end

  // ==========================================================
  // gain code
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      gain_code_ff <= `CTG_RST_GAIN;
    end else if (PIX_VALID) begin
      gain_code_ff <= gif.active[nxt_colour_sel];
    end
  end

  // ==========================================================
  // outputs
  assign RDATA = rdata_ff;
  assign RD_HIT = rd_hit_ff;
  assign PIX_GAIN_VALID = pix_valid_ff;
  assign PIX_COLOUR_SEL = colour_sel_ff;
  assign PIX_GAIN_CODE = gain_code_ff;
  assign LOWER_REF_CODE = lower_ref_ff;
  assign UPPER_REF_CODE = upper_ref_ff;
  assign BIAS_PIN_SEL = bias_sel_ff;
  assign SOFT_STANDBY = standby_ff;

endmodule : ctg_regs
